// >>> hw/adcsm_defines.vh
// adcsm_defines.vh: addresses, field positions, reset values and delay times
// assumes: included by adcsm_regs.v only; clock rate given in ns per cycle
`ifndef ADCSM_DEFINES_VH
`define ADCSM_DEFINES_VH

// ==========================================================================
// register addresses (5-bit register address of the command port)
`define ADCSM_ADDR_STATUS      5'h01
`define ADCSM_ADDR_RATE_FILT   5'h02
`define ADCSM_ADDR_CONV_CTRL   5'h03

// ==========================================================================
// reset values and unmapped read data
`define ADCSM_RST_RATE_FILT    8'h24
`define ADCSM_RST_CONV_CTRL    8'h01
`define ADCSM_UNMAPPED_DATA    8'h00

// ==========================================================================
// status bit positions
`define ADCSM_ST_LOCK          7
`define ADCSM_ST_CHKERR        6
`define ADCSM_ST_AMP_LO        5
`define ADCSM_ST_AMP_HI        4
`define ADCSM_ST_REF_LO        3
`define ADCSM_ST_NEWDATA       2
`define ADCSM_ST_CLKEXT        1
`define ADCSM_ST_RSTDET        0

// ==========================================================================
// rate_filter_select and conversion_control fields
`define ADCSM_RATE_MSB         7
`define ADCSM_RATE_LSB         3
`define ADCSM_FILT_MSB         2
`define ADCSM_FILT_LSB         0
`define ADCSM_CC_RSVD          7
`define ADCSM_MOD_MSB          6
`define ADCSM_MOD_LSB          5
`define ADCSM_SINGLE           4
`define ADCSM_DLY_MSB          3
`define ADCSM_DLY_LSB          0
`define ADCSM_RATE_TOP_IDX     5'h10
`define ADCSM_FILT_LAST_VALID  3'h4

// ==========================================================================
// clock and start delay times in ns
`define ADCSM_CLK_PERIOD_NS    50
`define ADCSM_DLY_T1_NS        50000
`define ADCSM_DLY_T2_NS        59000
`define ADCSM_DLY_T3_NS        67000
`define ADCSM_DLY_T4_NS        85000
`define ADCSM_DLY_T5_NS        119000
`define ADCSM_DLY_T6_NS        189000
`define ADCSM_DLY_T7_NS        328000
`define ADCSM_DLY_T8_NS        605000
`define ADCSM_DLY_T9_NS        1160000
`define ADCSM_DLY_T10_NS       2270000
`define ADCSM_DLY_T11_NS       4490000
`define ADCSM_DLY_T12_NS       8930000
`define ADCSM_DLY_T13_NS       17800000

`endif

// >>> hw/adcsm_regs.v
// adcsm_regs.v: status and mode registers of the converter, with start-delay sequencing
// assumes: a command decoder drives the byte register port and lock pulses on clk_sys;
// alarm comparators and the clock-detect level arrive asynchronously
`timescale 1ns/10ps
`include "adcsm_defines.vh"

// What this block does
// - status bit 7 shows write lock state
// - check mismatch sets sticky bit 6, host clears
// - amplifier low/high alarms, cleared at conversion start
// - reference low alarm, cleared at conversion start
// - bit 2 shows data new since last read
// - bit 1 reports automatic internal/external clock
// - bit 0 set on reset, host clears
// - rate code bits 7:3 select output rate
// - codes 10000-11111 all give top rate
// - filter field bits 2:0 selects filter
// - rate and filter register 02h, reset 24h
// - second mode register 03h, reset 01h
// - bits 6:5 select modulation mode
// - bit 4 single-shot, else continuous conversions
// - bits 3:0 select conversion start delay
module adcsm_regs #(
    parameter DLY8_CYC  = (`ADCSM_DLY_T8_NS  + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS,
    parameter DLY9_CYC  = (`ADCSM_DLY_T9_NS  + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS,
    parameter DLY10_CYC = (`ADCSM_DLY_T10_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS,
    parameter DLY11_CYC = (`ADCSM_DLY_T11_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS,
    parameter DLY12_CYC = (`ADCSM_DLY_T12_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS,
    parameter DLY13_CYC = (`ADCSM_DLY_T13_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS
) (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [4:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid,
    input  wire       lock_cmd,
    input  wire       unlock_cmd,
    input  wire       check_mismatch,
    input  wire       amp_low_in,
    input  wire       amp_high_in,
    input  wire       ref_low_in,
    input  wire       clk_ext_detect,
    input  wire       start_cmd,
    input  wire       stop_cmd,
    input  wire       conv_done,
    input  wire       data_read,
    output reg        conv_go,
    output wire       conv_active,
    output wire [4:0] rate_index,
    output wire       rate_fast_clk,
    output wire [2:0] filter_type,
    output wire       filter_reserved,
    output wire [1:0] modulation_mode,
    output wire       single_shot_select,
    output wire       start_delay_reserved
);

    // ======================================================================
    // delay counts, least times rounded up; whole integers first, then cut to counter width
    localparam integer DLY1_RAW = (`ADCSM_DLY_T1_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS;
    localparam integer DLY2_RAW = (`ADCSM_DLY_T2_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS;
    localparam integer DLY3_RAW = (`ADCSM_DLY_T3_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS;
    localparam integer DLY4_RAW = (`ADCSM_DLY_T4_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS;
    localparam integer DLY5_RAW = (`ADCSM_DLY_T5_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS;
    localparam integer DLY6_RAW = (`ADCSM_DLY_T6_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS;
    localparam integer DLY7_RAW = (`ADCSM_DLY_T7_NS + `ADCSM_CLK_PERIOD_NS - 1) / `ADCSM_CLK_PERIOD_NS;
    localparam [24:0] DLY1_CYC = DLY1_RAW[24:0];
    localparam [24:0] DLY2_CYC = DLY2_RAW[24:0];
    localparam [24:0] DLY3_CYC = DLY3_RAW[24:0];
    localparam [24:0] DLY4_CYC = DLY4_RAW[24:0];
    localparam [24:0] DLY5_CYC = DLY5_RAW[24:0];
    localparam [24:0] DLY6_CYC = DLY6_RAW[24:0];
    localparam [24:0] DLY7_CYC = DLY7_RAW[24:0];
    localparam [24:0] DLY8_C   = DLY8_CYC[24:0];
    localparam [24:0] DLY9_C   = DLY9_CYC[24:0];
    localparam [24:0] DLY10_C  = DLY10_CYC[24:0];
    localparam [24:0] DLY11_C  = DLY11_CYC[24:0];
    localparam [24:0] DLY12_C  = DLY12_CYC[24:0];
    localparam [24:0] DLY13_C  = DLY13_CYC[24:0];

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_DELAY = 2'h1;
    localparam [1:0] ST_RUN   = 2'h2;

    // ======================================================================
    // start delay table; code 0 gives one cycle, reserved codes fall back to default
    function [24:0] dly_cycles;
        input [3:0] code;
        begin
            case (code)
                4'h0:    dly_cycles = 25'h0000001;
                4'h1:    dly_cycles = DLY1_CYC;
                4'h2:    dly_cycles = DLY2_CYC;
                4'h3:    dly_cycles = DLY3_CYC;
                4'h4:    dly_cycles = DLY4_CYC;
                4'h5:    dly_cycles = DLY5_CYC;
                4'h6:    dly_cycles = DLY6_CYC;
                4'h7:    dly_cycles = DLY7_CYC;
                4'h8:    dly_cycles = DLY8_C;
                4'h9:    dly_cycles = DLY9_C;
                4'hA:    dly_cycles = DLY10_C;
                4'hB:    dly_cycles = DLY11_C;
                4'hC:    dly_cycles = DLY12_C;
                4'hD:    dly_cycles = DLY13_C;
                default: dly_cycles = DLY1_CYC;
            endcase
        end
    endfunction

    // ======================================================================
    // address decode shared by the write and read paths
    function [2:0] reg_hit;
        input [4:0] addr;
        begin
            if (addr == `ADCSM_ADDR_STATUS) begin
                reg_hit = 3'h1;
            end else if (addr == `ADCSM_ADDR_RATE_FILT) begin
                reg_hit = 3'h2;
            end else if (addr == `ADCSM_ADDR_CONV_CTRL) begin
                reg_hit = 3'h4;
            end else begin
                reg_hit = 3'h0;
            end
        end
    endfunction

    // ======================================================================
    // registers
    reg  [7:0]  rate_filter_select_reg;
    reg  [7:0]  conversion_control_reg;
    reg         write_protect_flag_reg;
    reg         check_error_flag_reg;
    reg  [2:0]  alarm_reg;
    reg         new_data_flag_reg;
    reg         reset_detected_reg;
    reg  [1:0]  state_reg;
    reg  [24:0] dly_cnt_reg;
    reg  [3:0]  sync1_reg;
    reg  [3:0]  sync2_reg;

    wire [2:0]  addr_hit   = reg_hit(reg_addr);
    wire        wr_ok      = reg_wr & ~write_protect_flag_reg;
    wire        wr_status  = wr_ok & addr_hit[0];
    wire        wr_rate    = wr_ok & addr_hit[1];
    wire        wr_conv    = wr_ok & addr_hit[2];
    wire        conv_start = (state_reg == ST_DELAY) & (dly_cnt_reg == 25'h0000001);
    wire [7:0]  status_val;
    wire [2:0]  alarm_next;
    wire        amp_under_range_alarm = alarm_reg[0];
    wire        amp_over_range_alarm  = alarm_reg[1];
    wire        reference_under_alarm = alarm_reg[2];

    // ======================================================================
    // range alarms: same set and clear for each comparator
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_alarm
            // a level still high at conversion start sets the alarm again
            assign alarm_next[gi] = sync2_reg[gi] | (alarm_reg[gi] & ~conv_start);
        end
    endgenerate

    // ======================================================================
    // pin synchronisers; first stage read only by the second
    always @(posedge clk_sys) begin
        if (rst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {clk_ext_detect, ref_low_in, amp_high_in, amp_low_in};
            sync2_reg <= sync1_reg;
        end
    end

    // ======================================================================
    // mode registers
    always @(posedge clk_sys) begin
        if (rst) begin
            rate_filter_select_reg <= `ADCSM_RST_RATE_FILT;
            conversion_control_reg <= `ADCSM_RST_CONV_CTRL;
        end else begin
            if (wr_rate) begin
                rate_filter_select_reg <= reg_wdata;
            end
            if (wr_conv) begin
                conversion_control_reg <= {1'b0, reg_wdata[6:0]};
            end
        end
    end

    // ======================================================================
    // status flags; every hardware set wins over a clear in the same cycle
    always @(posedge clk_sys) begin
        if (rst) begin
            write_protect_flag_reg    <= 1'b0;
            check_error_flag_reg      <= 1'b0;
            alarm_reg                 <= 3'h0;
            new_data_flag_reg         <= 1'b0;
            reset_detected_reg        <= 1'b1;
        end else begin
            if (lock_cmd) begin
                write_protect_flag_reg <= 1'b1;
            end else if (unlock_cmd) begin
                write_protect_flag_reg <= 1'b0;
            end
            // host writes 0 to clear; other status bits ignore the write
            check_error_flag_reg <= check_mismatch |
                (check_error_flag_reg & ~(wr_status & ~reg_wdata[`ADCSM_ST_CHKERR]));
            reset_detected_reg <= reset_detected_reg &
                ~(wr_status & ~reg_wdata[`ADCSM_ST_RSTDET]);
            alarm_reg <= alarm_next;
            new_data_flag_reg <= conv_done | (new_data_flag_reg & ~data_read);
        end
    end

    assign status_val = {write_protect_flag_reg, check_error_flag_reg, amp_under_range_alarm,
                         amp_over_range_alarm, reference_under_alarm, new_data_flag_reg,
                         sync2_reg[3], reset_detected_reg};

    // ======================================================================
    // read port; unmapped addresses answer zero
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                if (addr_hit[0]) begin
                    reg_rdata <= status_val;
                end else if (addr_hit[1]) begin
                    reg_rdata <= rate_filter_select_reg;
                end else if (addr_hit[2]) begin
                    reg_rdata <= conversion_control_reg;
                end else begin
                    reg_rdata <= `ADCSM_UNMAPPED_DATA;
                end
            end
        end
    end

    // ======================================================================
    // conversion sequencing: delay, then run; a mode write restarts it
    always @(posedge clk_sys) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            dly_cnt_reg <= 25'h0000000;
            conv_go     <= 1'b0;
        end else begin
            // a stop in the last delay cycle wins over the start pulse
            conv_go <= conv_start & ~stop_cmd;
            if (stop_cmd) begin
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (start_cmd) begin
                            state_reg   <= ST_DELAY;
                            dly_cnt_reg <= dly_cycles(conversion_control_reg[`ADCSM_DLY_MSB:`ADCSM_DLY_LSB]);
                        end
                    end
                    ST_DELAY: begin
                        if (wr_rate | wr_conv) begin
                            dly_cnt_reg <= dly_cycles(wr_conv ? reg_wdata[3:0] :
                                conversion_control_reg[`ADCSM_DLY_MSB:`ADCSM_DLY_LSB]);
                        end else if (conv_start) begin
                            state_reg <= ST_RUN;
                        end else begin
                            dly_cnt_reg <= dly_cnt_reg - 25'h0000001;
                        end
                    end
                    ST_RUN: begin
                        if (wr_rate | wr_conv) begin
                            state_reg   <= ST_DELAY;
                            dly_cnt_reg <= dly_cycles(wr_conv ? reg_wdata[3:0] :
                                conversion_control_reg[`ADCSM_DLY_MSB:`ADCSM_DLY_LSB]);
                        end else if (conv_done) begin
                            if (conversion_control_reg[`ADCSM_SINGLE]) begin
                                state_reg <= ST_IDLE;
                            end else begin
                                state_reg   <= ST_DELAY;
                                dly_cnt_reg <= dly_cycles(conversion_control_reg[`ADCSM_DLY_MSB:`ADCSM_DLY_LSB]);
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // decoded mode outputs for the converter core
    assign conv_active     = (state_reg != ST_IDLE);
    assign rate_fast_clk   = rate_filter_select_reg[`ADCSM_RATE_MSB];
    assign rate_index      = rate_fast_clk ? `ADCSM_RATE_TOP_IDX :
                             rate_filter_select_reg[`ADCSM_RATE_MSB:`ADCSM_RATE_LSB];
    assign filter_type     = rate_filter_select_reg[`ADCSM_FILT_MSB:`ADCSM_FILT_LSB];
    assign filter_reserved = (filter_type > `ADCSM_FILT_LAST_VALID);
    assign modulation_mode = conversion_control_reg[`ADCSM_MOD_MSB:`ADCSM_MOD_LSB];
    assign single_shot_select   = conversion_control_reg[`ADCSM_SINGLE];
    assign start_delay_reserved = (conversion_control_reg[3:1] == 3'h7);

endmodule // adcsm_regs

// >>> test/adcsm_regs_asserts.sv
// adcsm_regs_asserts.sv: port-level checks of the status and mode registers
// assumes: bound into adcsm_regs, one clock clk_sys, synchronous reset rst
`timescale 1ns/10ps
// ==================================================
// checker
module adcsm_regs_asserts (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       lock_cmd,
    input wire logic       unlock_cmd,
    input wire logic       start_cmd,
    input wire logic       stop_cmd,
    input wire logic       conv_go,
    input wire logic       conv_active,
    input wire logic [4:0] rate_index,
    input wire logic       rate_fast_clk,
    input wire logic [2:0] filter_type,
    input wire logic       filter_reserved,
    input wire logic [1:0] modulation_mode,
    input wire logic       single_shot_select,
    input wire logic       start_delay_reserved
);
    // lock wins when both commands arrive together
    logic lk_reg;
    always @(posedge clk_sys) begin
        lk_reg <= rst ? 1'b0 : (lock_cmd ? 1'b1 : (unlock_cmd ? 1'b0 : lk_reg));
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_read_answer: assert property (reg_rvalid == $past(reg_rd)) else $error("read answer timing");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    a_lock_status:
        assert property (reg_rd && reg_addr == 5'h01 |=> reg_rdata[7] == $past(lk_reg)) else $error("lock bit");
    a_locked_no_write:
        assert property (lk_reg && reg_wr |=> $stable({rate_index, filter_type, modulation_mode, single_shot_select}))
        else $error("write taken while locked");
    a_rate_readback:
        assert property (reg_rd && reg_addr == 5'h02 |=> reg_rdata[7] == rate_fast_clk && reg_rdata[2:0] == filter_type
        && (reg_rdata[7] || reg_rdata[7:3] == rate_index)) else $error("rate fields");
    a_rate_top: assert property (rate_fast_clk |-> rate_index == 5'h10) else $error("top rate");
    a_filter_rsvd: assert property (filter_reserved == (filter_type > 3'h4)) else $error("filter reserved");
    a_mode_readback:
        assert property (reg_rd && reg_addr == 5'h03 |=> reg_rdata[7:4] == {1'b0, modulation_mode, single_shot_select}
        && start_delay_reserved == (reg_rdata[3:0] > 4'hD)) else $error("mode fields");
    a_reset_values:
        assert property (disable iff (1'b0) rst |=> rate_index == 5'h04 && filter_type == 3'h4
        && modulation_mode == 2'h0 && !single_shot_select && !conv_go && !conv_active) else $error("reset values");
    a_go_single: assert property (conv_go |=> !conv_go) else $error("start pulse too long");
    a_start_taken: assert property (start_cmd && !stop_cmd && !conv_active |=> conv_active) else $error("start lost");
endmodule // adcsm_regs_asserts

bind adcsm_regs adcsm_regs_asserts chk (.*);

// >>> test/adcsm_host_model.sv
// adcsm_host_model.sv: host controller on the register command port
// assumes: clk_sys from the bench; the bench pops exp_q when read data returns
`timescale 1ns/10ps
// ==================================================
// host side
module adcsm_host_model (
    input  wire logic       clk_sys,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [4:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            lock_cmd,
    output logic            unlock_cmd,
    output logic            check_mismatch
);
    logic [7:0] exp_q[$];
    initial begin
        {reg_wr, reg_rd, lock_cmd, unlock_cmd, check_mismatch, reg_addr, reg_wdata} = 18'h00000;
    end
    // called at a falling edge; released strobes go low, address and data show the inverse, never stale values
    task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(negedge clk_sys);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
        @(negedge clk_sys);
        repeat ($urandom % 3) @(negedge clk_sys);
    endtask
    // flag clears are plain writes of 0
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 8'h00);
    endtask
    task automatic cmd(input logic [2:0] m);
        {lock_cmd, unlock_cmd, check_mismatch} = m;
        @(negedge clk_sys);
        {lock_cmd, unlock_cmd, check_mismatch} = 3'b000;
        @(negedge clk_sys);
    endtask
endmodule // adcsm_host_model

// >>> test/adcsm_regs_test.sv
// adcsm_regs_test.sv: self-checking bench for the status and mode registers
// assumes: host model drives the register port; small start delays for long codes
`timescale 1ns/10ps
`define CHK(g, e) chk(g, e)
// ==================================================
// bench
module adcsm_regs_test;
    logic        clk_sys, rst;
    logic        reg_wr, reg_rd, reg_rvalid, lock_cmd, unlock_cmd, check_mismatch;
    logic [4:0]  reg_addr, rate_index;
    logic [7:0]  reg_wdata, reg_rdata, d, m;
    logic        amp_low_in, amp_high_in, ref_low_in, clk_ext_detect;
    logic        start_cmd, stop_cmd, conv_done, data_read;
    logic        conv_go, conv_active, rate_fast_clk, filter_reserved, single_shot_select, start_delay_reserved;
    logic [2:0]  filter_type;
    logic [1:0]  modulation_mode;
    logic [31:0] seed_v;
    int          num_errors = 0, cmp_count = 0;
    adcsm_regs #(.DLY8_CYC(20), .DLY9_CYC(30), .DLY10_CYC(40), .DLY11_CYC(50), .DLY12_CYC(60), .DLY13_CYC(70)) DUT (.*);
    adcsm_host_model host (.*);
    always #25 clk_sys = ~clk_sys;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        // a read that never got its answer counts as a mismatch
        if (host.exp_q.size() != 0)
            num_errors++;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic pulse(input logic [2:0] p);
        {conv_done, data_read, stop_cmd} = p;
        @(negedge clk_sys);
        {conv_done, data_read, stop_cmd} = 3'b000;
    endtask
    // counts falling edges from the start request to the start pulse, bounded
    task automatic go_time(input logic [15:0] e);
        logic [15:0] n;
        n = 0;
        start_cmd = 1'b1;
        do begin
            @(negedge clk_sys);
            start_cmd = 1'b0;
            n++;
        end while (conv_go !== 1'b1 && n < 16'd3000);
        `CHK(n, e);
    endtask
    // read data is judged against the oldest note of the host
    always @(negedge clk_sys) begin
        if (reg_rvalid === 1'b1 && host.exp_q.size() > 0)
            `CHK(reg_rdata, host.exp_q.pop_front());
    end
    initial begin
        #(50 * 20000);
        num_errors++;
        give_verdict;
    end
    initial begin
        {clk_sys, rst} = 2'b01;
        {amp_low_in, amp_high_in, ref_low_in, clk_ext_detect} = 4'h0;
        {start_cmd, stop_cmd, conv_done, data_read} = 4'h0;
        seed_v = $urandom(32'hDF11);
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        host.rd(5'h02, 8'h24);
        host.rd(5'h03, 8'h01);
        host.rd(5'h01, 8'h01);
        host.rd(5'h1F, 8'h00);
        $display("test reset values done");
        host.wr(5'h01, 8'hFE);
        host.cmd(3'b001);
        host.rd(5'h01, 8'h40);
        host.wr(5'h01, 8'hBF);
        host.rd(5'h01, 8'h00);
        clk_ext_detect = 1'b1;
        repeat (4) @(negedge clk_sys);
        host.rd(5'h01, 8'h02);
        clk_ext_detect = 1'b0;
        $display("test status flags done");
        for (int i = 0; i < 32; i++) begin
            d = {i[4:0], i[2:0]};
            host.wr(5'h02, d);
            host.rd(5'h02, d);
            `CHK(rate_index, i[4] ? 5'h10 : i[4:0]);
            `CHK(filter_reserved, i[2:0] > 3'h4);
            m = $urandom;
            host.wr(5'h03, m);
            host.rd(5'h03, m & 8'h7F);
            `CHK({modulation_mode, start_delay_reserved}, {m[6:5], m[3:0] > 4'hD});
        end
        host.wr(5'h02, 8'h24);
        $display("test mode fields done");
        host.cmd(3'b110);
        host.rd(5'h01, 8'h80);
        host.wr(5'h02, 8'h5A);
        host.rd(5'h02, 8'h24);
        host.cmd(3'b010);
        host.rd(5'h01, 8'h00);
        $display("test write lock done");
        host.wr(5'h03, 8'h00);
        {amp_low_in, amp_high_in, ref_low_in} = 3'b111;
        repeat (4) @(negedge clk_sys);
        {amp_low_in, amp_high_in, ref_low_in} = 3'b000;
        repeat (4) @(negedge clk_sys);
        host.rd(5'h01, 8'h38);
        go_time(16'd2);
        host.rd(5'h01, 8'h00);
        pulse(3'b100);
        host.rd(5'h01, 8'h04);
        pulse(3'b010);
        host.rd(5'h01, 8'h00);
        `CHK(conv_active, 1'b1);
        pulse(3'b001);
        host.wr(5'h03, 8'h01);
        go_time(16'd1001);
        pulse(3'b001);
        host.wr(5'h03, 8'h10);
        go_time(16'd2);
        pulse(3'b100);
        `CHK(conv_active, 1'b0);
        $display("test conversion sequencing done");
        rst = 1'b1;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        host.rd(5'h01, 8'h01);
        host.rd(5'h03, 8'h01);
        $display("test second reset done");
        give_verdict;
    end
endmodule // adcsm_regs_test
